// >>> core/iem_pkg.sv
// constants for the shift and timer based i2c bus master
package iem_pkg;
    // register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SCL_CMP = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SHIFT_CMP = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_TX_BUF = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_RX_BUF = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

    // control field positions
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_TX_BEGIN = 1;
    localparam int CTRL_TX_END = 2;
    localparam int CTRL_RX_END = 3;

    // status field positions
    localparam int STAT_TX_EMPTY = 0;
    localparam int STAT_RX_FULL = 1;
    localparam int STAT_ACK_ERR = 2;
    localparam int STAT_BUSY = 3;
    localparam int STAT_SHIFT_OUT = 4;
    localparam int STAT_RX_OVERRUN = 5;

    // values after reset
    localparam logic RST_ENABLE = 1'b0;
    localparam logic RST_TX_BEGIN = 1'b0;
    localparam logic RST_TX_END = 1'b1;
    localparam logic RST_RX_END = 1'b0;
    localparam logic [15:0] RST_SCL_CMP = 16'h0000;
    localparam logic [15:0] RST_SHIFT_CMP = 16'h000F;

    // scl timer states, gray along idle-setup-run-stop
    typedef enum logic [1:0] {
        IEM_IDLE = 2'b00,
        IEM_SETUP = 2'b01,
        IEM_RUN = 2'b11,
        IEM_STOP = 2'b10
    } iem_state_t;
endpackage : iem_pkg

// >>> core/iem_sync.sv
// two flip-flop synchroniser for the bus pin inputs
`timescale 1ns/1ps
module iem_sync (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // pin side and synchronised side
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_sync
);
    logic [1:0] stage1;
    logic [1:0] next_stage1;
    logic [1:0] next_pin_sync;

    // pins idle high on an open-drain bus
    always_comb begin
        next_stage1 = pin_in;
        next_pin_sync = stage1;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= 2'h3;
            pin_sync <= 2'h3;
        end else begin
            stage1 <= next_stage1;
            pin_sync <= next_pin_sync;
        end
    end
endmodule : iem_sync

// >>> core/iem_master.sv
// i2c bus master built from a transmit and receive shifter and two timers
// Notes on behaviour
// - shift timer: one 16-bit counter, tx-flag-low triggered
// - shift timer steps once per scl pin edge
// - shift timer output starts at one when enabled
// - shift timer follows scl timer enable, never reset
// - shift timer inserts start bit, stop at compare
// - shift compare 0x0F: two edges per bit
// - tx buffer write clears flag, starts scl timer
// - end bit drives ack; rx end bit checks it
// - scl timer gives two extra edges per transfer
// - sda set during scl low before restart/stop
// - start bit before data, end bit at count zero
// - enabling transmit loads end bit at once
// - scl timer is dual 8-bit bit-rate counter
// - no arbitration, handshake or clock stretching
`timescale 1ns/1ps
module iem_master
    import iem_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire logic [iem_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [iem_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [iem_pkg::DATA_W-1:0] reg_rdata,
    // sda open-drain pin
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // scl open-drain pin
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe
);
    import iem_pkg::*;

    // register state
    logic enable;
    logic tx_begin;
    logic tx_end;
    logic rx_end;
    logic [15:0] scl_cmp;
    logic [15:0] shift_cmp;
    logic [7:0] tx_buf;
    logic tx_empty;
    logic [7:0] rx_buf;
    logic rx_full;
    logic ack_err;
    logic rx_overrun;
    // timer and shifter state
    iem_state_t state;
    logic [7:0] div_cnt;
    logic [7:0] edge_cnt;
    logic [15:0] shift_cnt;
    logic shift_out;
    logic ack_phase;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic sda_bit;
    logic scl_drive;
    logic scl_d;
    // next values
    logic next_enable;
    logic next_tx_begin;
    logic next_tx_end;
    logic next_rx_end;
    logic [15:0] next_scl_cmp;
    logic [15:0] next_shift_cmp;
    logic [7:0] next_tx_buf;
    logic next_tx_empty;
    logic [7:0] next_rx_buf;
    logic next_rx_full;
    logic next_ack_err;
    logic next_rx_overrun;
    iem_state_t next_state;
    logic [7:0] next_div_cnt;
    logic [7:0] next_edge_cnt;
    logic [15:0] next_shift_cnt;
    logic next_shift_out;
    logic next_ack_phase;
    logic [7:0] next_tx_sh;
    logic [7:0] next_rx_sh;
    logic next_sda_bit;
    logic next_scl_drive;
    logic [DATA_W-1:0] next_rdata;
    // decoded strobes and pin events
    logic [1:0] pins_sync;
    logic sda_s;
    logic scl_s;
    logic scl_rise;
    logic scl_fall;
    logic wr_ctrl;
    logic wr_tx;
    logic rd_rx;
    logic tick;
    logic timer_on;

    iem_sync u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in({scl_i, sda_i}),
        .pin_sync(pins_sync)
    );

    assign sda_s = pins_sync[0];
    assign scl_s = pins_sync[1];
    // edges come from the synchronised pin, so a slave holding scl low
    // is simply not seen by the scl timer, which keeps toggling
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
    assign wr_tx = reg_wr && (reg_addr == OFS_TX_BUF);
    assign rd_rx = reg_rd && (reg_addr == OFS_RX_BUF);
    assign tick = (div_cnt == scl_cmp[7:0]);
    assign timer_on = (state == IEM_RUN) || (state == IEM_STOP);

    always_comb begin
        next_enable = enable;
        next_tx_begin = tx_begin;
        next_tx_end = tx_end;
        next_rx_end = rx_end;
        next_scl_cmp = scl_cmp;
        next_shift_cmp = shift_cmp;
        next_tx_buf = tx_buf;
        next_tx_empty = tx_empty;
        next_rx_buf = rx_buf;
        next_rx_full = rx_full;
        next_ack_err = ack_err;
        next_rx_overrun = rx_overrun;
        next_state = state;
        next_div_cnt = div_cnt;
        next_edge_cnt = edge_cnt;
        next_shift_cnt = shift_cnt;
        next_shift_out = shift_out;
        next_ack_phase = ack_phase;
        next_tx_sh = tx_sh;
        next_rx_sh = rx_sh;
        next_sda_bit = sda_bit;
        next_scl_drive = scl_drive;

        // software side
        if (wr_ctrl) begin
            next_enable = reg_wdata[CTRL_ENABLE];
            next_tx_begin = reg_wdata[CTRL_TX_BEGIN];
            next_tx_end = reg_wdata[CTRL_TX_END];
            next_rx_end = reg_wdata[CTRL_RX_END];
            if (reg_wdata[CTRL_ENABLE] && !enable) begin
                next_sda_bit = reg_wdata[CTRL_TX_END];
            end
        end
        if (reg_wr && (reg_addr == OFS_SCL_CMP)) begin
            next_scl_cmp = reg_wdata[15:0];
        end
        if (reg_wr && (reg_addr == OFS_SHIFT_CMP)) begin
            next_shift_cmp = reg_wdata[15:0];
        end
        if (wr_tx) begin
            next_tx_buf = reg_wdata[7:0];
            next_tx_empty = 1'b0;
        end
        if (reg_wr && (reg_addr == OFS_STATUS)) begin
            if (reg_wdata[STAT_ACK_ERR]) begin
                next_ack_err = 1'b0;
            end
            if (reg_wdata[STAT_RX_OVERRUN]) begin
                next_rx_overrun = 1'b0;
            end
        end
        if (rd_rx) begin
            next_rx_full = 1'b0;
        end

        // scl timer, dual 8-bit: low byte divides, high byte counts edges
        next_div_cnt = tick ? 8'h00 : 8'(div_cnt + 8'h01);
        case (state)
            IEM_IDLE: begin
                next_div_cnt = 8'h00;
                // trigger is the tx flag, active low
                if (enable && !tx_empty) begin
                    next_state = IEM_SETUP;
                    next_tx_sh = tx_buf;
                    next_tx_empty = wr_tx ? 1'b0 : 1'b1;
                    next_sda_bit = tx_begin;
                    next_edge_cnt = scl_cmp[15:8];
                    next_shift_cnt = shift_cmp;
                    next_shift_out = 1'b1;
                    next_ack_phase = 1'b0;
                    next_scl_drive = 1'b0;
                end
            end
            IEM_SETUP: begin
                // start bit stands on sda for two scl phases, this one and the first run phase, 2 x (divider plus one) cycles, with scl high
                if (tick) begin
                    next_state = IEM_RUN;
                end
            end
            IEM_RUN: begin
                if (tick) begin
                    if (edge_cnt == 8'h00) begin
                        // compare reached: release scl, then the end bit
                        next_state = IEM_STOP;
                        next_scl_drive = 1'b0;
                    end else begin
                        next_scl_drive = ~scl_drive;
                        next_edge_cnt = 8'(edge_cnt - 8'h01);
                    end
                end
            end
            IEM_STOP: begin
                if (tick) begin
                    // sda changes only now, with scl already high
                    next_sda_bit = tx_end;
                    next_state = IEM_IDLE;
                end
            end
            default: begin
                next_state = IEM_IDLE;
            end
        endcase
        if (!enable) begin
            next_state = IEM_IDLE;
            next_scl_drive = 1'b0;
        end

        // shift timer, counting pin edges while the scl timer runs
        if (timer_on && (scl_rise || scl_fall)) begin
            next_shift_out = ~shift_out;
        end
        if (timer_on && scl_fall) begin
            if (shift_cnt == 16'h0000) begin
                // count spent: this edge carries the ack slot
                next_sda_bit = tx_end;
                next_ack_phase = 1'b1;
                next_shift_cnt = 16'(shift_cmp + 16'h0001);
                if (!tx_empty) begin
                    // double buffer refill; the top bit of an extra byte
                    // lands in scl low ahead of a restart or stop
                    next_tx_sh = tx_buf;
                    next_tx_empty = wr_tx ? 1'b0 : 1'b1;
                end
            end else begin
                next_sda_bit = tx_sh[7];
                next_tx_sh = {tx_sh[6:0], 1'b1};
                next_shift_cnt = 16'(shift_cnt - 16'h0001);
            end
        end
        if (timer_on && scl_rise) begin
            if (ack_phase) begin
                next_ack_phase = 1'b0;
                next_shift_cnt = 16'(shift_cnt - 16'h0001);
                if (sda_s != rx_end) begin
                    next_ack_err = 1'b1;
                end
                // store wins over a read in the same cycle
                next_rx_buf = rx_sh;
                next_rx_full = 1'b1;
                if (rx_full && !rd_rx) begin
                    next_rx_overrun = 1'b1;
                end
            end else begin
                next_rx_sh = {rx_sh[6:0], sda_s};
                if (shift_cnt != 16'h0000) begin
                    next_shift_cnt = 16'(shift_cnt - 16'h0001);
                end
            end
        end

        // read data, valid the cycle after the strobe only
        next_rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL: begin
                    next_rdata[CTRL_ENABLE] = enable;
                    next_rdata[CTRL_TX_BEGIN] = tx_begin;
                    next_rdata[CTRL_TX_END] = tx_end;
                    next_rdata[CTRL_RX_END] = rx_end;
                end
                OFS_SCL_CMP: next_rdata[15:0] = scl_cmp;
                OFS_SHIFT_CMP: next_rdata[15:0] = shift_cmp;
                OFS_RX_BUF: next_rdata[7:0] = rx_buf;
                OFS_STATUS: begin
                    next_rdata[STAT_TX_EMPTY] = tx_empty;
                    next_rdata[STAT_RX_FULL] = rx_full;
                    next_rdata[STAT_ACK_ERR] = ack_err;
                    next_rdata[STAT_BUSY] = (state != IEM_IDLE);
                    next_rdata[STAT_SHIFT_OUT] = shift_out;
                    next_rdata[STAT_RX_OVERRUN] = rx_overrun;
                end
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            enable <= RST_ENABLE;
            tx_begin <= RST_TX_BEGIN;
            tx_end <= RST_TX_END;
            rx_end <= RST_RX_END;
            scl_cmp <= RST_SCL_CMP;
            shift_cmp <= RST_SHIFT_CMP;
            tx_buf <= 8'h00;
            tx_empty <= 1'b1;
            rx_buf <= 8'h00;
            rx_full <= 1'b0;
            ack_err <= 1'b0;
            rx_overrun <= 1'b0;
            state <= IEM_IDLE;
            div_cnt <= 8'h00;
            edge_cnt <= 8'h00;
            shift_cnt <= 16'h0000;
            shift_out <= 1'b1;
            ack_phase <= 1'b0;
            tx_sh <= 8'hFF;
            rx_sh <= 8'h00;
            sda_bit <= 1'b1;
            scl_drive <= 1'b0;
            scl_d <= 1'b1;
            reg_rdata <= '0;
            sda_o <= 1'b0;
            sda_oe <= 1'b0;
            scl_o <= 1'b0;
            scl_oe <= 1'b0;
        end else begin
            enable <= next_enable;
            tx_begin <= next_tx_begin;
            tx_end <= next_tx_end;
            rx_end <= next_rx_end;
            scl_cmp <= next_scl_cmp;
            shift_cmp <= next_shift_cmp;
            tx_buf <= next_tx_buf;
            tx_empty <= next_tx_empty;
            rx_buf <= next_rx_buf;
            rx_full <= next_rx_full;
            ack_err <= next_ack_err;
            rx_overrun <= next_rx_overrun;
            state <= next_state;
            div_cnt <= next_div_cnt;
            edge_cnt <= next_edge_cnt;
            shift_cnt <= next_shift_cnt;
            shift_out <= next_shift_out;
            ack_phase <= next_ack_phase;
            tx_sh <= next_tx_sh;
            rx_sh <= next_rx_sh;
            sda_bit <= next_sda_bit;
            scl_drive <= next_scl_drive;
            scl_d <= scl_s;
            reg_rdata <= next_rdata;
            // open drain: the pins only ever pull low
            sda_o <= 1'b0;
            sda_oe <= ~next_sda_bit;
            scl_o <= 1'b0;
            scl_oe <= next_scl_drive;
        end
    end
endmodule : iem_master

// >>> sim/iem_master_asserts.sv
// concurrent checks on the register port and bus pins of the i2c master
`timescale 1ns/1ps
module iem_master_asserts
    import iem_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire logic [iem_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [iem_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [iem_pkg::DATA_W-1:0] reg_rdata,
    // bus pins
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic scl_o,
    input wire logic scl_oe
);
    import iem_pkg::*;
    logic [7:0] div;
    logic en;
    logic tx_end;
    logic scl_q;
    logic [9:0] hold;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // shadow of divider and enable, hold counts cycles since scl last moved
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div <= RST_SCL_CMP[7:0];
            en <= RST_ENABLE;
            tx_end <= RST_TX_END;
            scl_q <= 1'b0;
            hold <= 10'h000;
        end else begin
            if (reg_wr && reg_addr == OFS_SCL_CMP) div <= reg_wdata[7:0];
            if (reg_wr && reg_addr == OFS_CTRL) begin
                en <= reg_wdata[CTRL_ENABLE];
                tx_end <= reg_wdata[CTRL_TX_END];
            end
            scl_q <= scl_oe;
            // saturates so a long idle never wraps into a short one
            hold <= (scl_oe != scl_q) ? 10'h000 : hold + 10'(hold != 10'h3FF);
        end
    end
    sequence idle_bus;
        en && !sda_oe && !scl_oe && hold > {1'b0, div, 1'b0} + 10'h008;
    endsequence
    sequence tx_load;
        reg_wr && reg_addr == OFS_TX_BUF;
    endsequence
    sequence start_cond;
        sda_oe && !scl_oe;
    endsequence
    start_cond_a: assert property (idle_bus ##0 tx_load |-> ##[1:4] start_cond)
        else $error("no start condition after buffer write");
    sda_setup_a: assert property ($changed(sda_oe) |-> scl_oe || hold >= 10'(div))
        else $error("sda moved during a short scl high phase");
    scl_low_a: assert property ($fell(scl_oe) |-> hold == 10'(div))
        else $error("scl low phase not divider plus one");
    scl_high_a: assert property ($rose(scl_oe) |-> hold >= 10'(div))
        else $error("scl high phase too short");
    end_bit_a: assert property ($rose(en) |-> ##[0:2] sda_oe == !tx_end)
        else $error("end bit not driven on enable");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside its cycle");
    hole_zero_a: assert property (reg_rd && (reg_addr > OFS_STATUS
        || reg_addr == OFS_TX_BUF) |=> reg_rdata == '0)
        else $error("unmapped or write-only place reads nonzero");
    open_drain_a: assert property (!sda_o && !scl_o)
        else $error("pin driven high");
endmodule : iem_master_asserts

bind iem_master iem_master_asserts u_iem_master_asserts (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sda_o, .sda_oe, .scl_o, .scl_oe
);

// >>> sim/iem_slave_model.sv
// behavioural i2c slave on the open-drain bus
`timescale 1ns/1ps
module iem_slave_model (
    // bus lines, pulled up outside
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe,
    // behaviour
    input wire logic rd_mode,
    input wire logic ack_en,
    input wire logic [7:0] rd_byte
);
    int bit_no = 0;
    int stops = 0;
    logic [7:0] sh = 8'h00;
    logic [7:0] got [$];
    initial sda_oe = 1'b0;
    always @(negedge sda) if (scl) bit_no = 0;
    always @(posedge sda) if (scl) begin
        bit_no = 0;
        stops++;
    end
    always @(posedge scl) if (bit_no >= 1 && bit_no <= 8) begin
        sh = {sh[6:0], sda};
        if (bit_no == 8) got.push_back(sh);
    end
    // changes only after scl falls, so it never fakes a start or stop
    always @(negedge scl) begin
        bit_no = (bit_no == 9) ? 1 : bit_no + 1;
        if (rd_mode) sda_oe <= bit_no <= 8 && !rd_byte[8 - bit_no];
        else sda_oe <= bit_no == 9 && ack_en;
    end
endmodule : iem_slave_model

// >>> sim/iem_master_bench.sv
// self-checking bench for the i2c master register port and bus
`timescale 1ns/1ps
module iem_master_bench;
    import iem_pkg::*;
    localparam logic [7:0] DIV = 8'h07;
    localparam logic [7:0] RA [7] = '{OFS_CTRL, OFS_SCL_CMP, OFS_SHIFT_CMP,
        OFS_TX_BUF, OFS_RX_BUF, OFS_STATUS, 8'h18};
    localparam logic [31:0] RV [7] = '{32'h4, 32'h0, 32'hF, 32'h0, 32'h0, 32'h11, 32'h0};
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] rv;
    logic sda_o, sda_oe, scl_o, scl_oe, slv_oe;
    logic rd_mode = 1'b0;
    logic ack_en = 1'b1;
    int err_count = 0;
    int total_checks = 0;
    wire logic sda = !(slv_oe || (sda_oe && !sda_o));
    wire logic scl = !(scl_oe && !scl_o);
    iem_master u_iem_master (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe));
    iem_slave_model u_iem_slave_model (.scl(scl), .sda(sda), .sda_oe(slv_oe),
        .rd_mode(rd_mode), .ack_en(ack_en), .rd_byte(8'hBC));
    initial forever #4 clk_sys = ~clk_sys;
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask : rd
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // polling service, one status read every second cycle
    task automatic poll(input int b, input logic v);
        repeat (500) begin
            rd(OFS_STATUS);
            if (rv[b] === v) break;
        end
        chk("status wait", 32'(v), 32'(rv[b]));
    endtask : poll
    task automatic run(input int n, input logic [31:0] ctl, input logic [7:0] t0, t1,
        input logic [7:0] e0, e1, input logic ae);
        int s0;
        s0 = u_iem_slave_model.stops;
        u_iem_slave_model.got.delete();
        repeat (40) @(posedge clk_sys);
        wr(OFS_CTRL, ctl);
        wr(OFS_SCL_CMP, {16'h0, 8'((n * 9 + 1) * 2 - 1), DIV});
        rd(OFS_SCL_CMP);
        chk("scl compare", {16'h0, 8'((n * 9 + 1) * 2 - 1), DIV}, rv);
        wr(OFS_TX_BUF, {24'h0, t0});
        poll(STAT_TX_EMPTY, 1'b1);
        for (int i = 0; i < n; i++) begin
            wr(OFS_TX_BUF, {24'h0, (i + 1 < n) ? t1 : 8'h00});
            poll(STAT_RX_FULL, 1'b1);
            rd(OFS_RX_BUF);
            chk("rx byte", {24'h0, (i == 1) ? e1 : e0}, rv);
            chk("bus byte", {24'h0, (i == 1) ? e1 : e0}, {24'h0, u_iem_slave_model.got[i]});
        end
        poll(STAT_BUSY, 1'b0);
        rd(OFS_STATUS);
        chk("ack error", 32'(ae), 32'(rv[STAT_ACK_ERR]));
        chk("rx full", 32'h0, 32'(rv[STAT_RX_FULL]));
        // an even number of seen edges brings the shift timer back to one
        chk("shift out", 32'h1, 32'(rv[STAT_SHIFT_OUT]));
        chk("rx overrun", 32'h0, 32'(rv[STAT_RX_OVERRUN]));
        chk("stop seen", 32'(s0 + 1), 32'(u_iem_slave_model.stops));
        wr(OFS_STATUS, 32'h24);
        rd(OFS_STATUS);
        chk("ack clear", 32'h0, 32'(rv[STAT_ACK_ERR]));
    endtask : run
    task automatic final_report();
        if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (RA[i]) begin
            rd(RA[i]);
            chk("reset value", RV[i], rv);
        end
        // upper half of the compare word is not stored
        wr(OFS_SHIFT_CMP, 32'hABCD1234);
        rd(OFS_SHIFT_CMP);
        chk("shift compare", 32'h00001234, rv);
        wr(OFS_SHIFT_CMP, 32'h0000000F);
        // enable edge puts the end bit on sda at once
        wr(OFS_CTRL, 32'h1);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("end bit low", 32'h1, 32'(sda_oe));
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CTRL, 32'h5);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("end bit high", 32'h0, 32'(sda_oe));
        // begin bit set while idle must not move the bus
        wr(OFS_CTRL, 32'hF);
        rd(OFS_CTRL);
        chk("ctrl all", 32'hF, rv);
        chk("idle sda", 32'h0, 32'(sda_oe));
        run(2, 32'h5, 8'hA5, 8'h5A, 8'hA5, 8'h5A, 1'b0);
        ack_en <= 1'b0;
        run(1, 32'h5, 8'h3C, 8'h00, 8'h3C, 8'h00, 1'b1);
        rd_mode <= 1'b1;
        run(1, 32'hD, 8'hFF, 8'h00, 8'hBC, 8'h00, 1'b0);
        final_report();
    end
    initial begin
        #100000;
        err_count++;
        final_report();
    end
endmodule : iem_master_bench
